//--- sddc_card_model.sv
/*
 * Card in the socket: random terminal levels and a take signal that
 * stalls at random while slow is high. Assumes the seed is set by the bench.
 */
`timescale 1ns/10ps
`default_nettype none
module sddc_card_model
(
   // Clock and pacing
   input wire logic  ref_clk,
   input wire logic  slow,
   // Card terminals
   output var logic  cardSpeakerLine,
   output var logic  cardIoWidth16Line,
   output var logic  cardInputAckLine,
   output var logic  cardReady
);
   initial {cardSpeakerLine, cardIoWidth16Line, cardInputAckLine, cardReady} = 4'h1;
   // Levels move every cycle so a stuck copy is caught
   always @(posedge ref_clk)
   begin
      #1;
      {cardSpeakerLine, cardIoWidth16Line, cardInputAckLine} <= 3'($urandom);
      cardReady <= !slow || 1'($urandom_range(1));
   end
endmodule
`default_nettype wire

//--- sddc_defines.svh
/*
 * Constants for the socket distributed DMA configuration and decode block:
 * configuration offsets, field positions, reset values and encodings.
 * Assumes it is included by bare name from the package and the design file.
 */
`ifndef SDDC_DEFINES_SVH
`define SDDC_DEFINES_SVH

// Configuration offsets (byte addresses)
`define SDDC_OFF_REQ_SEL      8'h94
`define SDDC_OFF_BASE_CTRL    8'h98

// Reset values
`define SDDC_RST_REQ_SEL      32'h0000_0000
`define SDDC_RST_BASE_CTRL    32'h0000_0000

// Request-select field
`define SDDC_SEL_LSB          0
`define SDDC_SEL_MSB          1

// Base/control fields
`define SDDC_EN_BIT           0
`define SDDC_WID_LSB          1
`define SDDC_WID_MSB          2
`define SDDC_EXT_BIT          3
`define SDDC_BASE_LSB         4
`define SDDC_BASE_MSB         15

// Request-terminal encodings
`define SDDC_SEL_NONE         2'h0
`define SDDC_SEL_SPEAKER      2'h1
`define SDDC_SEL_IO16         2'h2
`define SDDC_SEL_CARD_INPUT_ACK_LINE       2'h3

// Card transfer width encodings
`define SDDC_WID_8            2'h0
`define SDDC_WID_16           2'h1

// Last beat index per prefetched word
`define SDDC_BEATS_WIDE       2'h1
`define SDDC_BEATS_NARROW     2'h3

`endif

//--- sddc_pkg.sv
/*
 * Types for the socket distributed DMA configuration and decode block.
 * Assumes sddc_defines.svh is on the include path.
 */
`include "sddc_defines.svh"

package sddc_pkg;

   // Whole state of the block, registered as one word
   typedef struct packed {
      logic [1:0]  dmaSel;       // Request terminal select
      logic [11:0] winBase;      // Window base, address bits 15..4
      logic [1:0]  xferWidth;    // Card transfer width code
      logic        decEn;        // Window decode enable
      logic [31:0] rdData;       // Configuration read data
      logic        rdValid;      // Read answer strobe
      logic        winHit;       // I/O address hit the window
      logic        dmaReq;       // Selected card request
      logic        spkNormal;    // Speaker line, non-DMA use
      logic        io16Normal;   // 16-bit indicate, non-DMA use
      logic        ackNormal;    // Input acknowledge, non-DMA use
      logic [31:0] word;         // Prefetched PCI word
      logic        wordWide;     // Word is split into 16-bit beats
      logic [1:0]  beat;         // Current beat index
      logic [15:0] cardData;     // Card-side beat data
      logic        cardValid;    // Card beat offered
      logic        pciReady;     // Free to take a PCI word
   } sddc_state_t;

endpackage

//--- sddc_socket_distributed_dma.sv
/*
 * Per-socket distributed DMA configuration, window decode, request
 * terminal selection and 32-to-16 bit card data splitter.
 * Assumes configuration accesses and I/O addresses are synchronous to
 * ref_clk, one instance per socket function.
 */
`timescale 1ns/10ps
`default_nettype none

`include "sddc_defines.svh"

// Functional notes
// - Select field picks card DMA request terminal
// - Select register bits 31..2 read zero
// - Bits 15..4 place the window base
// - Window address upper 16 bits are zero
// - Low four bits zero, excluded from decode
// - Bit 0 enables window decode
// - Bits 2..1 choose 8 or 16 bit
// - Extended addressing bit reads zero always
// - Control register bits 31..16 read zero
// - Card cycle never carries over 16 bits
// - Prefetch 32 bits, two back-to-back halves at 16 bit, four bytes at 8 bit
// - Registers at 94h and 98h, reset zero
module sddc_socket_distributed_dma
(
   // Clock, reset, enable
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic        ce,
   // Configuration access
   input  wire logic        cfgWrite,
   input  wire logic        cfgRead,
   input  wire logic [7:0]  cfgAddr,
   input  wire logic [3:0]  cfgByteEn,
   input  wire logic [31:0] cfgWdata,
   output logic      [31:0] cfgRdata,
   output logic             cfgRdValid,
   // PCI I/O address decode
   input  wire logic        ioValid,
   input  wire logic [31:0] ioAddr,
   output logic             windowHit,
   // Card terminals
   input  wire logic        cardSpeakerLine,
   input  wire logic        cardIoWidth16Line,
   input  wire logic        cardInputAckLine,
   output logic             cardDmaRequest,
   output logic             speakerNormal,
   output logic             ioWidth16Normal,
   output logic             inputAckNormal,
   // Prefetched PCI data toward the card
   input  wire logic        pciValid,
   input  wire logic [31:0] pciData,
   output logic             pciReady,
   output logic      [15:0] cardData,
   output logic             cardValid,
   input  wire logic        cardReady
);

   sddc_pkg::sddc_state_t st_r;   // Registered state
   sddc_pkg::sddc_state_t st_nxt; // Next state

   // Pick one card beat out of the held word; never wider than 16 bits
   function automatic logic [15:0] beatSlice(input logic [31:0] w,
                                             input logic        wide,
                                             input logic [1:0]  idx);
      logic [15:0] s;
      s = 16'h0000;
      if (wide)
      begin
         s = idx[0] ? w[31:16] : w[15:0];
      end
      else
      begin
         s = {8'h00, w[8*idx +: 8]};
      end
      return s;
   endfunction

   // Read-back images; reserved and fixed bits come back as zero
   function automatic logic [31:0] readImage(input sddc_pkg::sddc_state_t s,
                                             input logic [7:0] a);
      logic [31:0] d;
      d = 32'h0000_0000;
      if (a == `SDDC_OFF_REQ_SEL)
      begin
         d[`SDDC_SEL_MSB:`SDDC_SEL_LSB] = s.dmaSel;
      end
      else if (a == `SDDC_OFF_BASE_CTRL)
      begin
         d[`SDDC_BASE_MSB:`SDDC_BASE_LSB] = s.winBase;
         d[`SDDC_EXT_BIT]                 = 1'b0;
         d[`SDDC_WID_MSB:`SDDC_WID_LSB]   = s.xferWidth;
         d[`SDDC_EN_BIT]                  = s.decEn;
      end
      else
      begin
         d = 32'h0000_0000; // Other offsets belong to other blocks
      end
      return d;
   endfunction

   // Next-state logic for registers, decode, terminals and splitter
   always_comb
   begin
      st_nxt         = st_r;
      st_nxt.rdValid = 1'b0;

      // Register writes, per byte lane; only writable bits are kept
      if (cfgWrite && cfgAddr == `SDDC_OFF_REQ_SEL)
      begin
         if (cfgByteEn[0])
         begin
            st_nxt.dmaSel = cfgWdata[`SDDC_SEL_MSB:`SDDC_SEL_LSB];
         end
      end
      else if (cfgWrite && cfgAddr == `SDDC_OFF_BASE_CTRL)
      begin
         if (cfgByteEn[0])
         begin
            st_nxt.decEn      = cfgWdata[`SDDC_EN_BIT];
            st_nxt.xferWidth  = cfgWdata[`SDDC_WID_MSB:`SDDC_WID_LSB];
            st_nxt.winBase[3:0] = cfgWdata[7:4];
         end
         if (cfgByteEn[1])
         begin
            st_nxt.winBase[11:4] = cfgWdata[15:8];
         end
      end

      // Read answers one cycle after the strobe, image of current state
      if (cfgRead)
      begin
         st_nxt.rdData  = readImage(st_r, cfgAddr);
         st_nxt.rdValid = 1'b1;
      end

      // Window decode: upper 16 bits must be zero, whole 16-byte block hits
      st_nxt.winHit = ioValid && st_r.decEn
                      && (ioAddr[31:16] == 16'h0000)
                      && (ioAddr[15:4] == st_r.winBase);

      // Request terminal routing; an unselected terminal keeps normal use
      st_nxt.dmaReq     = 1'b0;
      st_nxt.spkNormal  = cardSpeakerLine;
      st_nxt.io16Normal = cardIoWidth16Line;
      st_nxt.ackNormal  = cardInputAckLine;
      case (st_r.dmaSel)
         `SDDC_SEL_SPEAKER:
         begin
            st_nxt.dmaReq    = cardSpeakerLine;
            st_nxt.spkNormal = 1'b0;
         end
         `SDDC_SEL_IO16:
         begin
            st_nxt.dmaReq     = cardIoWidth16Line;
            st_nxt.io16Normal = 1'b0;
         end
         `SDDC_SEL_CARD_INPUT_ACK_LINE:
         begin
            st_nxt.dmaReq    = cardInputAckLine;
            st_nxt.ackNormal = 1'b0;
         end
         default:
         begin
            st_nxt.dmaReq = 1'b0;
         end
      endcase

      // Splitter: a beat leaves when the card takes it
      if (st_r.cardValid && cardReady)
      begin
         if (st_r.beat == (st_r.wordWide ? `SDDC_BEATS_WIDE : `SDDC_BEATS_NARROW))
         begin
            st_nxt.cardValid = 1'b0;
            st_nxt.pciReady  = 1'b1;
         end
         else
         begin
            // Next half or byte follows in the very next cycle
            st_nxt.beat     = 2'(st_r.beat + 2'h1);
            st_nxt.cardData = beatSlice(st_r.word, st_r.wordWide, st_nxt.beat);
         end
      end

      // Take a whole 32-bit word only while empty; reserved widths act as 8-bit
      if (st_r.pciReady && pciValid)
      begin
         st_nxt.word      = pciData;
         st_nxt.wordWide  = (st_r.xferWidth == `SDDC_WID_16);
         st_nxt.beat      = 2'h0;
         st_nxt.cardData  = beatSlice(pciData, st_nxt.wordWide, 2'h0);
         st_nxt.cardValid = 1'b1;
         st_nxt.pciReady  = 1'b0;
      end
   end

   // State register; the enable freezes everything
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         st_r           <= '0;
         st_r.pciReady  <= 1'b1;
      end
      else if (ce)
      begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign cfgRdata        = st_r.rdData;
   assign cfgRdValid      = st_r.rdValid;
   assign windowHit       = st_r.winHit;
   assign cardDmaRequest  = st_r.dmaReq;
   assign speakerNormal   = st_r.spkNormal;
   assign ioWidth16Normal = st_r.io16Normal;
   assign inputAckNormal  = st_r.ackNormal;
   assign pciReady        = st_r.pciReady;
   assign cardData        = st_r.cardData;
   assign cardValid       = st_r.cardValid;

endmodule

`default_nettype wire

//--- sddc_socket_distributed_dma_chk.sv
/*
 * Port-level checker for the socket distributed DMA block.
 * Assumes strobes are offered only while ce is high; frozen cycles are masked.
 */
`timescale 1ns/10ps
`default_nettype none
module sddc_socket_distributed_dma_chk
(
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        srst,
   input wire logic        ce,
   // Configuration access
   input wire logic        cfgRead,
   input wire logic [7:0]  cfgAddr,
   input wire logic [31:0] cfgRdata,
   input wire logic        cfgRdValid,
   // Window decode
   input wire logic        ioValid,
   input wire logic [31:0] ioAddr,
   input wire logic        windowHit,
   // Splitter
   input wire logic        pciValid,
   input wire logic [31:0] pciData,
   input wire logic        pciReady,
   input wire logic [15:0] cardData,
   input wire logic        cardValid,
   input wire logic        cardReady
);
   // One clock domain, reset masks everything
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst || !ce);

   a_read_answer: assert property (cfgRead |=> cfgRdValid)
      else $error("read strobe got no answer");
   a_read_once: assert property (!cfgRead |=> !cfgRdValid)
      else $error("read answer without a read");
   a_sel_reserved: assert property (
      cfgRdValid && $past(cfgAddr) == 8'h94 |-> cfgRdata[31:2] == 30'h0)
      else $error("select register reserved bits set");
   a_ctrl_reserved: assert property (
      cfgRdValid && $past(cfgAddr) == 8'h98 |-> cfgRdata[31:16] == 16'h0000 && !cfgRdata[3])
      else $error("control register fixed bits set");
   a_upper_miss: assert property (
      ioValid && ioAddr[31:16] != 16'h0000 |=> !windowHit)
      else $error("hit above the low 64K");
   a_idle_miss: assert property (!ioValid |=> !windowHit)
      else $error("hit without an address");
   // A stalled beat must not move or vanish
   a_beat_hold: assert property (
      cardValid && !cardReady |=> cardValid && $stable(cardData))
      else $error("stalled beat changed");
   // Low byte of the first beat comes straight from the taken word
   a_first_beat: assert property (
      pciValid && pciReady |=> cardValid && cardData[7:0] == $past(pciData[7:0]))
      else $error("first beat wrong");
endmodule
bind sddc_socket_distributed_dma sddc_socket_distributed_dma_chk i_chk (.ref_clk, .srst, .ce, .cfgRead, .cfgAddr,
   .cfgRdata, .cfgRdValid, .ioValid, .ioAddr, .windowHit, .pciValid, .pciData,
   .pciReady, .cardData, .cardValid, .cardReady);
`default_nettype wire

//--- test_socket_distributed_dma_config_decode.sv
/*
 * Self-checking bench: registers, terminal select, window decode, splitter.
 * Assumes the checker is bound by its own file.
 */
`timescale 1ns/10ps
`default_nettype none
module test_socket_distributed_dma_config_decode;
   logic ref_clk = 0, srst = 1, ce = 1, cfgWrite = 0, cfgRead = 0, ioValid = 0, pciValid = 0;
   logic [7:0] cfgAddr = 0;
   logic [3:0] cfgByteEn = 4'hF;
   logic [31:0] cfgWdata = 0, ioAddr = 0, pciData = 0, cfgRdata, d, a;
   logic cfgRdValid, windowHit, cardSpeakerLine, cardIoWidth16Line, cardInputAckLine;
   logic cardDmaRequest, speakerNormal, ioWidth16Normal, inputAckNormal, slow = 0;
   logic pciReady, cardValid, cardReady;
   logic [15:0] cardData, beats[$];
   logic [31:0] words[2];
   logic [2:0] prevL, m;
   int fails = 0, checksDone = 0, nb;

   sddc_socket_distributed_dma i_dut (.ref_clk, .srst, .ce, .cfgWrite, .cfgRead, .cfgAddr, .cfgByteEn,
      .cfgWdata, .cfgRdata, .cfgRdValid, .ioValid, .ioAddr, .windowHit, .cardSpeakerLine,
      .cardIoWidth16Line, .cardInputAckLine, .cardDmaRequest, .speakerNormal,
      .ioWidth16Normal, .inputAckNormal, .pciValid, .pciData, .pciReady, .cardData,
      .cardValid, .cardReady);
   sddc_card_model i_card (.ref_clk, .slow, .cardSpeakerLine, .cardIoWidth16Line,
      .cardInputAckLine, .cardReady);

   initial forever #2 ref_clk = ~ref_clk;
   // Terminal levels as seen at the last edge
   always @(posedge ref_clk) prevL <= {cardInputAckLine, cardIoWidth16Line, cardSpeakerLine};
   // Collect every beat the card takes
   always @(posedge ref_clk) if (!srst && cardValid && cardReady) beats.push_back(cardData);

   task automatic check(input logic ok);
      checksDone++;
      if (ok !== 1'b1)
      begin
         fails++;
         $display("mismatch at %0t: unexpected value", $time);
      end
   endtask
   task automatic cyc;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
      cyc;
      cfgWrite = 1;
      cfgAddr = ad;
      cfgWdata = dt;
      cyc;
      cfgWrite = 0;
   endtask
   // Read answer stands just after the taking edge
   task automatic rd(input logic [7:0] ad, input logic [31:0] ex);
      cyc;
      cfgRead = 1;
      cfgAddr = ad;
      cyc;
      cfgRead = 0;
      check(cfgRdValid === 1'b1 && cfgRdata === ex);
   endtask
   // Offer a word only when the splitter is empty
   task automatic send(input logic [31:0] w);
      for (int t = 0; t < 60 && pciReady !== 1'b1; t++) cyc;
      pciValid = 1;
      pciData = w;
      cyc;
      pciValid = 0;
   endtask
   // Expected beat: 16-bit halves, else bytes in the low lane
   function automatic logic [15:0] beatOf(input logic [31:0] w, input int wd, input int i);
      return (wd == 1) ? w[16*i +: 16] : {8'h00, w[8*i +: 8]};
   endfunction
   task automatic tallyAndFinish;
      $display("checks %0d mismatches %0d", checksDone, fails);
      if (fails == 0 && checksDone > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Watchdog: the whole run needs well under this span
   initial
   begin
      #100000;
      fails++;
      $display("mismatch at %0t: watchdog ran out", $time);
      tallyAndFinish;
   end
   initial
   begin
      void'($urandom(57765));
      repeat (20) @(posedge ref_clk);
      #1 srst = 0;
      rd(8'h94, 32'h0000_0000);
      rd(8'h98, 32'h0000_0000);
      rd(8'h90, 32'h0000_0000);
      // Every request terminal code, reserved bits written high
      for (int s = 0; s < 4; s++)
      begin
         wr(8'h94, 32'hFFFF_FFFC | s);
         rd(8'h94, s);
         m = (s == 0) ? 3'b000 : 3'b001 << (s - 1);
         repeat (6)
         begin
            cyc;
            check(cardDmaRequest === |(prevL & m));
            check({inputAckNormal, ioWidth16Normal, speakerNormal} === (prevL & ~m));
         end
      end
      // Random control images, then decode with enable off and on
      for (int e = 0; e < 2; e++)
      begin
         d = $urandom;
         d[0] = e[0];
         wr(8'h98, d);
         rd(8'h98, d & 32'h0000_FFF7);
         for (int k = 0; k < 3; k++)
         begin
            a = {16'h0000, d[15:4], 4'($urandom)};
            if (k == 1) a = a ^ (32'h0000_0010 << $urandom_range(11));
            if (k == 2) a[31:16] = 16'($urandom_range(16'hFFFF, 1));
            cyc;
            ioValid = 1;
            ioAddr = a;
            cyc;
            ioValid = 0;
            check(windowHit === (e == 1 && k == 0));
         end
      end
      // Lane 1 alone clears only base bits 15..8; other offsets drop writes
      cfgByteEn = 4'h2;
      wr(8'h98, 32'h0000_0000);
      cfgByteEn = 4'hF;
      wr(8'h9C, 32'hFFFF_FFFF);
      rd(8'h98, d & 32'h0000_00F7);
      rd(8'h94, 32'h0000_0003);
      // A write while the enable is low is lost
      cyc;
      ce = 0;
      wr(8'h98, 32'h0000_FFFF);
      ce = 1;
      rd(8'h98, d & 32'h0000_00F7);
      // Two words per width code, card stalling on odd codes
      for (int w = 0; w < 4; w++)
      begin
         wr(8'h98, 32'(w) << 1);
         slow = w[0];
         beats.delete();
         nb = (w == 1) ? 2 : 4;
         for (int n = 0; n < 2; n++)
         begin
            words[n] = $urandom;
            send(words[n]);
         end
         for (int t = 0; t < 100 && !(pciReady === 1'b1 && cardValid === 1'b0); t++) cyc;
         check(pciReady === 1'b1 && cardValid === 1'b0);
         check(beats.size() == 2 * nb);
         for (int i = 0; i < 2 * nb; i++) check(beats[i] === beatOf(words[i/nb], w, i%nb));
      end
      tallyAndFinish;
   end
endmodule
`default_nettype wire
